// >>> rtl/fre_top.sv
// Purpose: Fault reaction unit: fault pin or emergency signal on the chain link.
// Assumes: All inputs synchronous to mclk; link lines carry plain levels.
// Notes:   Interface A and B face the two chain neighbours.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Period detector for one link interface.
module fre_det #(
  parameter int PMIN = 3847,
  parameter int PMAX = 4166
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       rx,    // Received line level.
  input  wire logic       gate,  // High while we drive this interface.
  input  wire logic [4:0] need,  // Periods needed for a detection.
  output logic            hit    // One-cycle detection pulse.
);

  logic        rx_q;   // Previous line level for edge finding.
  logic        seen_q; // A first rising edge has been seen.
  logic [15:0] gap_q;  // Cycles since the last rising edge.
  logic [4:0]  cnt_q;  // Valid periods counted so far.
  logic        rise;
  logic        good;

  assign rise = rx & ~rx_q;
  // A period is good when the edge spacing lies in the frequency window.
  assign good = seen_q && (32'(gap_q) + 1 >= PMIN) && (32'(gap_q) + 1 <= PMAX);

  // Edge spacing counter; saturates so a dead line cannot wrap into the window.
  always_ff @(posedge mclk) begin
    if (!rst_n || gate || rise) begin
      gap_q <= 16'h0000;
    end else if (32'(gap_q) < PMAX) begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  // Period counting; our own transmission is not heard back.
  always_ff @(posedge mclk) begin
    rx_q <= rx;
    hit  <= 1'b0;
    if (!rst_n || gate) begin
      seen_q <= 1'b0;
      cnt_q  <= 5'h00;
    end else if (rise) begin
      seen_q <= 1'b1;
      if (good && (cnt_q + 5'h01 >= need)) begin
        hit   <= 1'b1;
        cnt_q <= 5'h00;
      end else if (good) begin
        cnt_q <= cnt_q + 5'h01;
      end else begin
        cnt_q <= 5'h00; // A bad spacing restarts the count from this edge.
      end
    end else if (32'(gap_q) >= PMAX) begin
      seen_q <= 1'b0;
      cnt_q  <= 5'h00;
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////////
// Top of the fault reaction unit.
module fre_top #(
  parameter int HALF_CYC = fre_pkg::EMG_HALF_CYC,
  parameter int PMIN_CYC = fre_pkg::EMG_PMIN_CYC,
  parameter int PMAX_CYC = fre_pkg::EMG_PMAX_CYC,
  parameter int DIAG_CYC = fre_pkg::DIAG_MAX_CYC,
  parameter int WD_CYC   = fre_pkg::WD_MAX_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire fre_pkg::fre_bus_t           bus,
  output fre_pkg::fre_bus_t                unused_bus_echo,
  output logic [fre_pkg::DATA_W-1:0]       rdata,
  input  wire logic [fre_pkg::NFLT-1:0]    fault_in,
  input  wire logic                        sleep_mode,
  input  wire logic                        a_is_host,
  input  wire logic                        diag_busy,
  input  wire logic                        diag_from_sleep,
  input  wire logic                        diag_delay_short,
  input  wire logic                        link_a_rx,
  input  wire logic                        link_b_rx,
  output fre_pkg::fre_link_t               link_a,
  output fre_pkg::fre_link_t               link_b,
  output logic                             fault_pin_o,
  output logic                             fault_pin_oe,
  output logic                             wake_req,
  output logic                             sleep_ret,
  output logic                             hold_awake,
  output logic                             irq
);

  localparam int HALF = HALF_CYC;

  logic                     sel_q;   // Reaction select: 1 emergency, 0 pin.
  logic [fre_pkg::NFLT-1:0] fmask_q; // Fault mask, set bit suppresses.
  logic [fre_pkg::NFLT-1:0] fstat_q; // Latched faults.
  logic [fre_pkg::NIRQ-1:0] istat_q; // Sticky interrupt events.
  logic [fre_pkg::NIRQ-1:0] imask_q; // Interrupt enables.
  logic [fre_pkg::NIRQ-1:0] ev;      // Events of this cycle.
  fre_pkg::fre_state_t      st_q;    // Link activity state.
  logic [1:0]               side_q;  // Bit 0 drives A, bit 1 drives B.
  logic [15:0]              half_q;  // Half period counter.
  logic [5:0]               per_q;   // Transmitted periods.
  logic                     lvl_q;   // Transmitted level.
  logic                     trig;    // OR of unmasked faults.
  logic                     trig_q;
  logic                     rise;
  logic                     pend_q;  // Own emission waiting for the link.
  logic                     woken_q; // Woken by the emergency signal.
  logic                     done;
  logic                     det_a;
  logic                     det_b;
  logic                     acc_a;
  logic                     acc_b;
  logic [4:0]               need;
  logic [31:0]              wd_q;    // Hold-awake timer.
  logic [31:0]              dg_q;    // Diagnostic cycle timer.
  logic                     late;
  logic                     wr_fstat;
  logic                     wr_istat;

  // The register request has no outputs of its own; tied off from reset.
  always_ff @(posedge mclk) begin
    unused_bus_echo <= '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault trigger.
  assign trig = |(fault_in & ~fmask_q);
  assign rise = trig & ~trig_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Detection and acceptance.
  // A sleeping or woken device listens for the short count, otherwise the idle count.
  assign need = (woken_q || sleep_mode) ? 5'(fre_pkg::EMG_DET_WOKEN)
                                        : 5'(fre_pkg::EMG_DET_IDLE);

  fre_det #(.PMIN(PMIN_CYC), .PMAX(PMAX_CYC)) u_det_a (
    .mclk (mclk),
    .rst_n(rst_n),
    .rx   (link_a_rx),
    .gate (link_a.oe),
    .need (need),
    .hit  (det_a)
  );

  fre_det #(.PMIN(PMIN_CYC), .PMAX(PMAX_CYC)) u_det_b (
    .mclk (mclk),
    .rst_n(rst_n),
    .rx   (link_b_rx),
    .gate (link_b.oe),
    .need (need),
    .hit  (det_b)
  );

  // Asleep either side is accepted; awake only the side away from the host.
  assign acc_a = det_a && (st_q == fre_pkg::ST_IDLE) && (sleep_mode || !a_is_host);
  assign acc_b = det_b && (st_q == fre_pkg::ST_IDLE) && (sleep_mode || a_is_host);

  ////////////////////////////////////////////////////////////////////////////
  // Link state machine and waveform generator.
  assign done = (st_q != fre_pkg::ST_IDLE) && (32'(half_q) == HALF - 1) && !lvl_q
                && (32'(per_q) == fre_pkg::EMG_TX_PER - 1);

  // Forwarding wins over a pending own emission; the emission follows after.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q   <= fre_pkg::ST_IDLE;
      side_q <= 2'b00;
      half_q <= 16'h0000;
      per_q  <= 6'h00;
      lvl_q  <= 1'b0;
    end else begin
      case (st_q)
        fre_pkg::ST_IDLE: begin
          half_q <= 16'h0000;
          per_q  <= 6'h00;
          lvl_q  <= 1'b1;
          if (acc_a || acc_b) begin
            st_q   <= fre_pkg::ST_FWD;
            side_q <= acc_a ? 2'b10 : 2'b01;
          end else if (pend_q) begin
            st_q   <= fre_pkg::ST_EMIT;
            side_q <= 2'b11; // Own emission goes to both neighbours.
          end
        end
        fre_pkg::ST_EMIT, fre_pkg::ST_FWD: begin
          if (32'(half_q) == HALF - 1) begin
            half_q <= 16'h0000;
            lvl_q  <= ~lvl_q;
            if (!lvl_q) begin
              per_q <= per_q + 6'h01;
            end
          end else begin
            half_q <= half_q + 16'h0001;
          end
          if (done) begin
            st_q   <= fre_pkg::ST_IDLE;
            side_q <= 2'b00;
          end
        end
        default: begin
          st_q <= fre_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Link pins come straight from flops; idle lines are released.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link_a <= '0;
      link_b <= '0;
    end else begin
      link_a.oe <= side_q[0] && !done;
      link_b.oe <= side_q[1] && !done;
      link_a.tx <= side_q[0] && !done && lvl_q;
      link_b.tx <= side_q[1] && !done && lvl_q;
    end
  end

  // A trigger with the emergency reaction selected queues an emission.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
    end else if (rise && sel_q) begin
      pend_q <= 1'b1;
    end else if (st_q == fre_pkg::ST_IDLE && !(acc_a || acc_b)) begin
      pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep handling: wake on detection, go back after forwarding.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      woken_q   <= 1'b0;
      wake_req  <= 1'b0;
      sleep_ret <= 1'b0;
    end else begin
      wake_req  <= (acc_a || acc_b) && sleep_mode;
      sleep_ret <= done && woken_q && st_q == fre_pkg::ST_FWD;
      if ((acc_a || acc_b) && sleep_mode) begin
        woken_q <= 1'b1;
      end else if (done && st_q == fre_pkg::ST_FWD) begin
        woken_q <= 1'b0;
      end
    end
  end

  // A pin fault seen in a diagnostic run from sleep keeps the device awake.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hold_awake <= 1'b0;
      wd_q       <= 32'h0000_0000;
    end else if (rise && !sel_q && diag_from_sleep) begin
      hold_awake <= 1'b1;
      wd_q       <= 32'h0000_0000;
    end else if (hold_awake) begin
      wd_q <= wd_q + 32'h0000_0001;
      if (32'(wd_q) >= WD_CYC - 1) begin
        hold_awake <= 1'b0;
      end
    end
  end

  // Diagnostic cycle watch; only meaningful with the short delay setting.
  assign late = diag_busy && diag_delay_short && (32'(dg_q) == DIAG_CYC);

  always_ff @(posedge mclk) begin
    if (!rst_n || !diag_busy) begin
      dg_q <= 32'h0000_0000;
    end else if (32'(dg_q) <= DIAG_CYC) begin
      dg_q <= dg_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault pin: driven to the rail while a latched unmasked fault stands, the pin reaction is selected and the device is awake.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fault_pin_o  <= 1'b0;
      fault_pin_oe <= 1'b0;
    end else begin
      fault_pin_o  <= !sel_q && |(fstat_q & ~fmask_q) && !sleep_mode;
      fault_pin_oe <= !sel_q && |(fstat_q & ~fmask_q) && !sleep_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file.
  assign wr_fstat = bus.wr && bus.addr == fre_pkg::OFF_FSTAT;
  assign wr_istat = bus.wr && bus.addr == fre_pkg::OFF_ISTAT;
  assign ev = {late, (acc_a || acc_b) && sleep_mode, done, acc_a || acc_b, rise};

  // Control and mask registers.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sel_q   <= fre_pkg::CTRL_SEL_RST;
      fmask_q <= fre_pkg::FMASK_RST;
      imask_q <= fre_pkg::IMASK_RST;
    end else if (bus.wr) begin
      if (bus.addr == fre_pkg::OFF_CTRL) begin
        sel_q <= bus.wdata[fre_pkg::CTRL_SEL_BIT];
      end
      if (bus.addr == fre_pkg::OFF_FMASK) begin
        fmask_q <= bus.wdata[fre_pkg::NFLT-1:0];
      end
      if (bus.addr == fre_pkg::OFF_IMASK) begin
        imask_q <= bus.wdata[fre_pkg::NIRQ-1:0];
      end
    end
  end

  // Sticky flags: write one to clear, a new set in the same cycle wins.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fstat_q <= '0;
      istat_q <= '0;
    end else begin
      fstat_q <= (fstat_q & ~(wr_fstat ? bus.wdata[fre_pkg::NFLT-1:0] : '0)) | fault_in;
      istat_q <= (istat_q & ~(wr_istat ? bus.wdata[fre_pkg::NIRQ-1:0] : '0)) | ev;
    end
  end

  // Interrupt level from the next flag values, so it rises with the flag.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((istat_q & ~(wr_istat ? bus.wdata[fre_pkg::NIRQ-1:0] : '0)) | ev) & imask_q);
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge mclk) begin
    if (!rst_n || !bus.rd) begin
      rdata <= '0;
    end else begin
      case (bus.addr)
        fre_pkg::OFF_CTRL:   rdata <= 32'(sel_q);
        fre_pkg::OFF_FMASK:  rdata <= 32'(fmask_q);
        fre_pkg::OFF_FSTAT:  rdata <= 32'(fstat_q);
        fre_pkg::OFF_ISTAT:  rdata <= 32'(istat_q);
        fre_pkg::OFF_IMASK:  rdata <= 32'(imask_q);
        fre_pkg::OFF_STATUS: rdata <= 32'({trig, hold_awake, woken_q,
                                           st_q != fre_pkg::ST_IDLE, fault_pin_o});
        default:             rdata <= '0;
      endcase
    end
  end

endmodule

// >>> rtl/fre_pkg.sv
// Purpose: Shared constants and types of the fault reaction unit.
// Assumes: 200 MHz mclk, register port with 8-bit address and 32-bit data.
// Notes:   Every offset, field position, reset value and timing count lives here.
package fre_pkg;

  localparam int ADDR_W = 8;  // Register port address width.
  localparam int DATA_W = 32; // Register port data width.
  localparam int NFLT   = 8;  // Number of fault sources.
  localparam int NIRQ   = 5;  // Number of interrupt events.

  // Register offsets (byte addresses, one word each).
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FMASK  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FSTAT  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ISTAT  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_IMASK  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;

  // Control field: 0 selects the fault pin, 1 the emergency signal.
  localparam int CTRL_SEL_BIT = 0;
  localparam logic CTRL_SEL_RST = 1'b0;
  localparam logic [NFLT-1:0] FMASK_RST = 8'h00;
  localparam logic [NIRQ-1:0] IMASK_RST = 5'h00;

  // Fault source bit positions.
  localparam int FLT_CELL_OVUV = 0;
  localparam int FLT_NTC       = 1;
  localparam int FLT_OPEN_LOAD = 2;
  localparam int FLT_BAL_OCUC  = 3;
  localparam int FLT_ADC_CROSS = 4;
  localparam int FLT_OVERTEMP  = 5;
  localparam int FLT_REG_CRC   = 6;
  localparam int FLT_INTERNAL  = 7;

  // Interrupt event bit positions.
  localparam int IRQ_FAULT = 0; // Unmasked fault trigger rose.
  localparam int IRQ_DET   = 1; // Emergency signal accepted.
  localparam int IRQ_DONE  = 2; // Emission or forwarding finished.
  localparam int IRQ_WAKE  = 3; // Wake-up requested by the link.
  localparam int IRQ_LATE  = 4; // Diagnostic cycle overran its bound.

  // Status field positions.
  localparam int ST_PIN_BIT   = 0;
  localparam int ST_BUSY_BIT  = 1;
  localparam int ST_WOKEN_BIT = 2;
  localparam int ST_HOLD_BIT  = 3;
  localparam int ST_TRIG_BIT  = 4;

  // Timing.
  localparam int CLK_HZ        = 200_000_000;
  localparam int EMG_FREQ_HZ   = 50_000; // Nominal emergency signal frequency.
  localparam int EMG_FMIN_HZ   = 48_000;
  localparam int EMG_FMAX_HZ   = 52_000;
  localparam int EMG_HALF_CYC  = CLK_HZ / (2 * EMG_FREQ_HZ);
  localparam int EMG_PMIN_CYC  = (CLK_HZ + EMG_FMAX_HZ - 1) / EMG_FMAX_HZ;
  localparam int EMG_PMAX_CYC  = CLK_HZ / EMG_FMIN_HZ;
  localparam int EMG_TX_PER    = 32; // Transmitted periods.
  localparam int EMG_DET_IDLE  = 16; // Periods to detect while idle.
  localparam int EMG_DET_WOKEN = 4;  // Periods to detect after wake-up.
  localparam int DIAG_MAX_US   = 1200; // Diagnostic cycle bound, 1.2 ms.
  localparam int DIAG_MAX_CYC  = DIAG_MAX_US * (CLK_HZ / 1_000_000);
  localparam int WD_MAX_CYC    = 2_000_000; // Watchdog hold, plain default.

  // Register port request.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } fre_bus_t;

  // One link interface as driven by this unit.
  typedef struct packed {
    logic tx;
    logic oe;
  } fre_link_t;

  typedef enum logic [1:0] {ST_IDLE, ST_EMIT, ST_FWD} fre_state_t;

endpackage

// >>> test/fre_props.sv
// Purpose: Port-level checks of the fault reaction unit.
// Assumes: One clock domain and a synchronous active-low reset.
// Notes:   Long spans are counted in helper logic rather than unrolled.
`timescale 1ns/100ps

module fre_props #(
  parameter int HALF_CYC = 2000,
  parameter int DIAG_CYC = 240000,
  parameter int WD_CYC   = 2000000
) (
  input wire logic                       mclk,
  input wire logic                       rst_n,
  input wire fre_pkg::fre_bus_t          bus,
  input wire logic [fre_pkg::DATA_W-1:0] rdata,
  input wire logic                       sleep_mode,
  input wire fre_pkg::fre_link_t         link_a,
  input wire fre_pkg::fre_link_t         link_b,
  input wire logic                       fault_pin_o,
  input wire logic                       fault_pin_oe,
  input wire logic                       wake_req,
  input wire logic                       sleep_ret,
  input wire logic                       hold_awake
);
  localparam int HALF = HALF_CYC; // Cycles in one tx half period.
  int   ha_q; // Cycles that link A tx has stood unchanged.
  int   pc_q; // Rising edges of link A while it is driven.
  int   hw_q; // Cycles that hold_awake has stood high.
  logic ga_q; // Last driven level of link A.

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  //////////////////////////////////////////////////////////////////////////////
  // Link A waveform counters; they restart whenever the line is released.
  always_ff @(posedge mclk) begin
    if (!rst_n || !link_a.oe) begin
      ha_q <= 0;
      pc_q <= 0;
    end else begin
      ha_q <= (link_a.tx != ga_q) ? 0 : ha_q + 1;
      pc_q <= (link_a.tx && !ga_q) ? pc_q + 1 : pc_q;
    end
  end

  // The driven level is remembered so that a start with tx high counts as an edge.
  always_ff @(posedge mclk) begin
    ga_q <= rst_n && link_a.oe && link_a.tx;
  end

  // Hold time counter; a runaway hold would pass unnoticed without it.
  always_ff @(posedge mclk) begin
    hw_q <= (!rst_n || !hold_awake) ? 0 : hw_q + 1;
  end

  //////////////////////////////////////////////////////////////////////////////
  pin_enable_a: assert property (fault_pin_o == fault_pin_oe)
    else $error("fault pin level and enable differ");
  pin_sleep_a: assert property (sleep_mode |=> !fault_pin_o)
    else $error("fault pin high while asleep");
  pin_cause_a: assert property ($rose(fault_pin_o) |-> $past(!sleep_mode))
    else $error("fault pin rose from sleep");
  tx_start_a: assert property ($rose(link_a.oe) |-> link_a.tx)
    else $error("link A emission did not start high");
  txb_start_a: assert property ($rose(link_b.oe) |-> link_b.tx)
    else $error("link B emission did not start high");
  tx_half_a: assert property (link_a.oe && $past(link_a.oe) && link_a.tx != ga_q
    |-> ha_q == HALF - 1) else $error("link A half period wrong");
  tx_count_a: assert property ($fell(link_a.oe) |-> pc_q == fre_pkg::EMG_TX_PER)
    else $error("link A period count wrong");
  wake_asleep_a: assert property (wake_req |-> $past(sleep_mode))
    else $error("wake request while awake");
  wake_pulse_a: assert property (wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  ret_quiet_a: assert property (sleep_ret |=> !link_a.oe && !link_b.oe)
    else $error("sleep return while a link is driven");
  rd_idle_a: assert property (!$past(bus.rd) |-> rdata == '0)
    else $error("read data outside the read answer cycle");
  hold_bound_a: assert property (hold_awake |-> hw_q <= WD_CYC + 2)
    else $error("hold awake outlived the watchdog span");

  wake_c: cover property (wake_req);
  ret_c: cover property (sleep_ret);
  emit_end_c: cover property ($fell(link_a.oe));
  hold_c: cover property ($fell(hold_awake));
endmodule

bind fre_top fre_props #(.HALF_CYC(HALF_CYC), .DIAG_CYC(DIAG_CYC), .WD_CYC(WD_CYC)) u_props (
  .mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .sleep_mode(sleep_mode),
  .link_a(link_a), .link_b(link_b), .fault_pin_o(fault_pin_o),
  .fault_pin_oe(fault_pin_oe), .wake_req(wake_req), .sleep_ret(sleep_ret),
  .hold_awake(hold_awake));

// >>> test/fre_nbr.sv
// Purpose: Chain neighbour model facing one link interface of the unit.
// Assumes: Plain line levels, no pull resistor on the link.
// Notes:   Released line keeps its last driven level, low after each emit.
`timescale 1ns/100ps

module fre_nbr #(parameter int HALF = 2000) (
  input  wire logic               mclk,
  input  wire fre_pkg::fre_link_t peer, // What the unit drives toward us.
  output logic                    rx    // Level the unit receives from us.
);
  int   rises  = 0;    // Rising edges of the unit's driven signal.
  logic last_q = 1'b0; // Last driven level seen from the unit.

  initial rx = 1'b0;

  // Receive side counts whole periods of what the unit emits toward us.
  always @(posedge mclk) begin
    if (peer.oe && peer.tx && !last_q) rises <= rises + 1;
    last_q <= peer.oe && peer.tx;
  end

  // Emits n periods at the nominal rate: n+1 rising edges, then release low.
  task automatic emit(input int n);
    for (int i = 0; i < 2 * (n + 1); i++) begin
      repeat (HALF) @(posedge mclk);
      rx <= ~rx;
    end
  endtask
endmodule

// >>> test/fre_top_test.sv
// Purpose: Self-checking bench of the fault reaction unit.
// Assumes: Shortened watchdog and diagnostic spans set at the instance.
// Notes:   Emergency periods run ten times shorter than the real ones.
`timescale 1ns/100ps

module fre_top_test;
  localparam int WD = 100; // Shortened watchdog hold.
  localparam int DG = 200; // Shortened diagnostic bound.
  localparam int HC = 200; // Tenfold shortened half period; window 385..417.
  logic                    mclk = 1'b0;
  logic                    rst_n;
  fre_pkg::fre_bus_t       bus;
  logic [31:0]             rdata;
  logic [7:0]              fault_in;
  logic                    sleep_mode, a_is_host, diag_busy, diag_from_sleep, diag_short;
  logic                    link_a_rx, link_b_rx, pin_o, pin_oe, wake_req, sleep_ret;
  logic                    hold_awake, irq;
  fre_pkg::fre_link_t      link_a, link_b;
  int                      failures = 0, checked = 0, wakes = 0, rets = 0, b_seen = 0;
  logic [31:0]             seed = 32'h0001_0B31;
  logic [31:0]             v;
  logic [7:0]              m_fmask; // Model copy of the mask register.
  int                      exp_q[$]; // Model pin reaction per fault source.

  initial forever #2.5 mclk = ~mclk;

  fre_top #(.HALF_CYC(HC), .PMIN_CYC(385), .PMAX_CYC(417), .DIAG_CYC(DG), .WD_CYC(WD)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .bus(bus), .unused_bus_echo(), .rdata(rdata),
    .fault_in(fault_in), .sleep_mode(sleep_mode), .a_is_host(a_is_host),
    .diag_busy(diag_busy), .diag_from_sleep(diag_from_sleep),
    .diag_delay_short(diag_short), .link_a_rx(link_a_rx), .link_b_rx(link_b_rx),
    .link_a(link_a), .link_b(link_b), .fault_pin_o(pin_o), .fault_pin_oe(pin_oe),
    .wake_req(wake_req), .sleep_ret(sleep_ret), .hold_awake(hold_awake), .irq(irq));
  fre_nbr #(.HALF(HC)) i_nbr_a (.mclk(mclk), .peer(link_a), .rx(link_a_rx));
  fre_nbr #(.HALF(HC)) i_nbr_b (.mclk(mclk), .peer(link_b), .rx(link_b_rx));

  //////////////////////////////////////////////////////////////////////////////
  // Event counters, so that one-cycle pulses are never missed by sampling.
  always @(posedge mclk) begin
    if (wake_req === 1'b1) wakes <= wakes + 1;
    if (sleep_ret === 1'b1) rets <= rets + 1;
    if (link_b.oe === 1'b1) b_seen <= 1;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic test_done();
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Waits n edges and lands on the falling edge, where outputs are settled.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  // The read answer stands only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask

  // A hang in any wait is cut short here and counted as a mismatch.
  initial begin
    repeat (80000) @(posedge mclk);
    failures++;
    test_done();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {bus, fault_in, sleep_mode, a_is_host, diag_busy, diag_from_sleep} = '0;
    {rst_n, diag_short} = 2'b01;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(fre_pkg::OFF_CTRL, v);
    chk("ctrl reset", v, 32'h0);
    rd(8'h18, v);
    chk("unmapped", v, 32'h0);
    // Random mask; source 0 stays unmasked for the later scenarios.
    m_fmask = xs() & 8'hFE;
    for (int i = 0; i < fre_pkg::NFLT; i++) exp_q.push_back(!m_fmask[i]);
    wr(fre_pkg::OFF_FMASK, m_fmask);
    wr(fre_pkg::OFF_IMASK, 32'h1);
    rd(fre_pkg::OFF_FMASK, v);
    chk("fmask", v, m_fmask);
    for (int i = 0; i < fre_pkg::NFLT; i++) begin
      @(posedge mclk);
      fault_in <= 8'h01 << i;
      tick(3);
      chk("pin on fault", pin_o, exp_q.pop_front());
      rd(fre_pkg::OFF_FSTAT, v);
      chk("fstat", v, 32'h1 << i);
      fault_in <= 8'h00;
      wr(fre_pkg::OFF_FSTAT, 32'hFF);
      tick(2);
      chk("pin cleared", pin_o, 1'b0);
    end
    // Interrupt raised, masked, unmasked and cleared.
    chk("irq raised", irq, 1'b1);
    wr(fre_pkg::OFF_IMASK, 32'h0);
    tick(2);
    chk("irq masked", irq, 1'b0);
    wr(fre_pkg::OFF_IMASK, 32'h1);
    wr(fre_pkg::OFF_ISTAT, 32'h1F);
    tick(2);
    chk("irq cleared", irq, 1'b0);
    // Sleep releases the pin; the latched fault brings it back on wake.
    fault_in <= 8'h01;
    tick(3);
    chk("pin set", pin_o, 1'b1);
    sleep_mode <= 1'b1;
    tick(2);
    chk("pin asleep", pin_o, 1'b0);
    sleep_mode <= 1'b0;
    fault_in <= 8'h00;
    tick(3);
    chk("pin rewoken", pin_o, 1'b1);
    wr(fre_pkg::OFF_FSTAT, 32'hFF);
    // Fault in a diagnostic run from sleep holds the device awake.
    {diag_from_sleep, diag_busy} <= 2'b11;
    fault_in <= 8'h01;
    tick(3);
    chk("hold on", hold_awake, 1'b1);
    tick(WD + 5);
    chk("hold off", hold_awake, 1'b0);
    tick(DG);
    rd(fre_pkg::OFF_ISTAT, v);
    chk("diag late", v[fre_pkg::IRQ_LATE], 1'b1);
    {diag_from_sleep, diag_busy, fault_in} <= '0;
    wr(fre_pkg::OFF_FSTAT, 32'hFF);
    // Asleep: one period short of the woken count must not wake the device.
    sleep_mode <= 1'b1;
    i_nbr_b.emit(fre_pkg::EMG_DET_WOKEN - 1);
    tick(3000);
    chk("no early wake", wakes, 0);
    i_nbr_b.emit(fre_pkg::EMG_DET_WOKEN);
    chk("wake", wakes, 1);
    chk("fwd opposite", link_a.oe, 1'b1);
    for (int n = 0; n < 14000 && link_a.oe === 1'b1; n++) @(posedge mclk);
    tick(5);
    chk("fwd periods", i_nbr_a.rises, fre_pkg::EMG_TX_PER);
    chk("fwd not back", b_seen, 0);
    chk("sleep return", rets, 1);
    // Awake only the far side counts, and it needs the idle count.
    sleep_mode <= 1'b0;
    i_nbr_b.emit(fre_pkg::EMG_DET_IDLE);
    i_nbr_a.emit(fre_pkg::EMG_DET_IDLE - 1);
    tick(3000);
    chk("idle short", b_seen, 0);
    i_nbr_a.emit(fre_pkg::EMG_DET_IDLE);
    chk("idle fwd", link_b.oe, 1'b1);
    for (int n = 0; n < 14000 && link_b.oe === 1'b1; n++) @(posedge mclk);
    // Awake with the emergency reaction: both neighbours get the signal.
    wr(fre_pkg::OFF_CTRL, 32'h1);
    @(posedge mclk);
    fault_in <= 8'h01;
    tick(4);
    chk("emit both", {link_a.oe, link_a.tx, link_b.oe, link_b.tx}, 4'hF);
    chk("no pin", pin_o, 1'b0);
    // Reset in mid-emission must silence the links and the selection.
    rst_n <= 1'b0;
    fault_in <= 8'h00;
    tick(2);
    rst_n <= 1'b1;
    chk("links quiet", {link_a.oe, link_b.oe}, 2'b00);
    rd(fre_pkg::OFF_CTRL, v);
    chk("ctrl reset", v, 32'h0);
    test_done();
  end
endmodule
